// file: verilog/usbd_pkg.sv
// Constants, field layouts and carriers for the USB device endpoint block.
// Assumes a single 25 MHz system clock shared by bus and engine logic.
package usbd_pkg;
    localparam int CLK_MHZ   = 25;
    // Bus idle time before suspend, in microseconds
    localparam int SUSP_US   = 3000;
    localparam int SUSP_CYC  = SUSP_US * CLK_MHZ;
    // Remote wake K drive time, in microseconds
    localparam int RWK_US    = 1000;
    localparam int RWK_CYC   = RWK_US * CLK_MHZ;
    localparam int CNT_W     = 17;
    localparam int BUF_BYTES = 512;
    localparam int NUM_EP    = 8;
    localparam int FIFO_D    = 8;

    localparam logic [9:0] A_INT   = 10'h000;
    localparam logic [9:0] A_CTRL  = 10'h004;
    localparam logic [9:0] A_EPST  = 10'h008;
    localparam logic [9:0] A_BUS   = 10'h00C;
    localparam logic [9:0] A_EPCFG = 10'h040;
    localparam int BUF_SEL = 9;

    localparam int I_WAKE = 0;
    localparam int I_PLUG = 1;
    localparam int I_USB  = 2;
    localparam int I_BUS  = 3;
    localparam int I_EP   = 16;

    localparam logic [1:0] ST_NONE  = 2'h0;
    localparam logic [1:0] ST_INACK = 2'h1;
    localparam logic [1:0] ST_OUTAK = 2'h2;
    localparam logic [1:0] ST_SETUP = 2'h3;

    // Per-endpoint configuration word, low 24 bits of its register
    typedef struct packed {
        logic       tog;
        logic [1:0] ttype;
        logic       armed;
        logic       dir_in;
        logic [9:0] cnt;
        logic [8:0] seg;
    } usbd_ep_s;
    localparam usbd_ep_s EP_RST = 24'h000000;

    typedef struct packed {
        logic       valid;
        logic       setup;
        logic       dir_in;
        logic [2:0] ep;
    } usbd_tok_s;

    typedef enum logic [1:0] {FS_IDLE, FS_OUT, FS_IN, FS_INW} usbd_fsm_e;
endpackage

// file: verilog/usbd_core.sv
// USB device endpoint logic: shared packet buffer, eight endpoints,
// event flags, suspend, remote wake and forced SE0; also its OUT FIFO.
// Assumes the serial engine runs on clk and speaks the token/byte ports.
//
// Contract
// - 512-byte buffer shared by software and engine
// - Endpoint data starts at its segment address
// - Eight endpoints, each IN or OUT
// - All transfer types, within the buffer
// - Track toggle, state, address, status per endpoint
// - One interrupt line for four event classes
// - Events set flags; endpoint detail readable
// - SE0 control forces lines low, disables function
// - Suspend after 3 ms bus idle
// - Remote wake signalled while suspended on request
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module usbd_fifo #(
    parameter int W = 8,
    parameter int D = usbd_pkg::FIFO_D
) (
    input  wire logic         clk,       // System clock
    input  wire logic         nrst,      // Async reset, low
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Not full
    input  wire logic [W-1:0] in_data,   // Write data
    output logic              out_valid, // Not empty
    input  wire logic         out_ready, // Read accept
    output logic      [W-1:0] out_data   // Head word
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   n;
    } usbd_fq_s;

    usbd_fq_s       s;
    usbd_fq_s       next_s;
    logic [W-1:0]   mem [D];
    logic           wr;
    logic           rd;

    assign in_ready  = (s.n != (AW+1)'(D));
    assign out_valid = (s.n != '0);
    assign out_data  = mem[s.rp];
    assign wr        = in_valid & in_ready;
    assign rd        = out_valid & out_ready;

    always_comb
    begin
        next_s = s;
        if (wr)
        begin
            next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
        end
        if (rd)
        begin
            next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
        end
        if (wr && !rd)
        begin
            next_s.n = s.n + 1'b1;
        end
        else if (rd && !wr)
        begin
            next_s.n = s.n - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr)
        begin
            mem[s.wp] <= in_data;
        end
    end
endmodule

module usbd_core #(
    parameter int unsigned SUSP_CYC = usbd_pkg::SUSP_CYC,
    parameter int unsigned RWK_CYC  = usbd_pkg::RWK_CYC
) (
    input  wire logic              clk,       // 25 MHz clock
    input  wire logic              nrst,      // Async reset, low
    input  wire logic [9:0]        addr,      // Register byte address
    input  wire logic [31:0]       wdata,     // Write data
    input  wire logic              wr_en,     // Write strobe
    input  wire logic              rd_en,     // Read strobe
    output logic      [31:0]       rdata,     // Read data, next cycle
    input  wire usbd_pkg::usbd_tok_s tok,     // Token from engine
    input  wire logic              rx_valid,  // OUT byte valid
    input  wire logic [7:0]        rx_data,   // OUT byte
    input  wire logic              rx_end,    // OUT packet good end
    output logic                   rx_ready,  // OUT byte accepted
    output logic                   tx_valid,  // IN byte valid
    output logic      [7:0]        tx_data,   // IN byte
    output logic                   tx_last,   // Last IN byte
    input  wire logic              tx_ready,  // Engine takes IN byte
    input  wire logic              hs_ack,    // Host ACK to IN data
    output logic                   resp_ack,  // OUT packet stored
    output logic                   resp_nak,  // Token refused
    output logic                   ep_toggle, // Current data toggle
    input  wire logic              dp_i,      // D+ line level
    input  wire logic              dm_i,      // D- line level
    input  wire logic              vbus_i,    // Cable power sense
    output logic                   dp_o,      // D+ drive value
    output logic                   dm_o,      // D- drive value
    output logic                   dp_oe,     // Line drive enable
    output logic                   irq,       // Interrupt request
    output logic                   suspended  // Suspend state
);
    localparam int CW = usbd_pkg::CNT_W;
    localparam int NE = usbd_pkg::NUM_EP;

    typedef struct packed {
        logic [2:0]           dp;   // Sync and edge stages
        logic [2:0]           dm;
        logic [2:0]           vb;
        usbd_pkg::usbd_fsm_e  fsm;
        usbd_pkg::usbd_ep_s [NE-1:0] ep;
        logic [2*NE-1:0]      eps;
        logic [3:0]           ints;
        logic [NE-1:0]        epf;
        logic                 se0;
        logic                 rwk;
        logic                 kdrv;
        logic                 susp;
        logic [CW-1:0]        idle;
        logic [CW-1:0]        rwkc;
        logic [2:0]           cur;
        logic                 setup;
        logic [8:0]           ptr;
        logic [9:0]           cnt;
        logic                 endp;
        logic                 rdp;
        logic                 txv;
        logic [7:0]           txd;
        logic                 txl;
        logic [31:0]          rdat;
        logic                 rdbuf;
        logic                 ack;
        logic                 nak;
    } usbd_st_s;

    usbd_st_s           s;
    usbd_st_s           next_s;
    logic [7:0]         buf_mem [usbd_pkg::BUF_BYTES];
    logic [7:0]         mem_q;
    logic [8:0]         maddr;
    logic               mwe;
    logic [7:0]         mwd;
    logic               bus_buf;
    logic               f_ov;
    logic               f_rdy;
    logic [7:0]         f_d;
    logic               f_fire;
    logic               f_irdy;
    logic               line_j;
    logic               tok_ok;
    logic [3:0]         set_i;
    logic [NE-1:0]      set_e;
    logic [3:0]         clr_i;
    logic [NE-1:0]      clr_e;
    usbd_pkg::usbd_ep_s te;

    // Software always wins the buffer port so the bus never waits
    assign bus_buf  = (wr_en | rd_en) & addr[usbd_pkg::BUF_SEL];
    assign f_rdy    = (s.fsm == usbd_pkg::FS_OUT) & ~bus_buf;
    assign f_fire   = f_ov & f_rdy;
    assign rx_ready = f_irdy & (s.fsm == usbd_pkg::FS_OUT);
    assign line_j   = s.dp[1] & ~s.dm[1];
    assign te       = s.ep[tok.ep];
    assign tok_ok   = te.armed & (te.dir_in == tok.dir_in) & ~(tok.setup & tok.dir_in);

    usbd_fifo #(.W(8), .D(usbd_pkg::FIFO_D)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (rx_valid & (s.fsm == usbd_pkg::FS_OUT)),
        .in_ready  (f_irdy),
        .in_data   (rx_data),
        .out_valid (f_ov),
        .out_ready (f_rdy),
        .out_data  (f_d)
    );

    assign maddr = bus_buf ? addr[8:0] : s.ptr;
    assign mwe   = bus_buf ? wr_en : f_fire;
    assign mwd   = bus_buf ? wdata[7:0] : f_d;

    always_ff @(posedge clk)
    begin
        if (mwe)
        begin
            buf_mem[maddr] <= mwd;
        end
        mem_q <= buf_mem[maddr];
    end

    always_comb
    begin
        next_s = s;
        set_i  = '0;
        set_e  = '0;
        clr_i  = '0;
        clr_e  = '0;
        next_s.ack   = 1'b0;
        next_s.nak   = 1'b0;
        next_s.rdbuf = 1'b0;
        next_s.dp    = {s.dp[1:0], dp_i};
        next_s.dm    = {s.dm[1:0], dm_i};
        next_s.vb    = {s.vb[1:0], vbus_i};
        if (s.vb[2] != s.vb[1])
        begin
            set_i[usbd_pkg::I_PLUG] = 1'b1;
        end
        if (wr_en && !addr[usbd_pkg::BUF_SEL])
        begin
            if (addr == usbd_pkg::A_INT)
            begin
                clr_i = wdata[3:0];
                clr_e = wdata[usbd_pkg::I_EP +: NE];
            end
            if (addr == usbd_pkg::A_CTRL)
            begin
                next_s.se0 = wdata[0];
                next_s.rwk = wdata[1];
            end
            if (addr[9:5] == usbd_pkg::A_EPCFG[9:5])
            begin
                next_s.ep[addr[4:2]] = usbd_pkg::usbd_ep_s'(wdata[23:0]);
            end
        end
        if (rd_en)
        begin
            next_s.rdbuf = addr[usbd_pkg::BUF_SEL];
            case (addr)
                usbd_pkg::A_INT:  next_s.rdat = {8'h00, s.epf, 12'h000, s.ints};
                usbd_pkg::A_CTRL: next_s.rdat = {30'h0, s.rwk, s.se0};
                usbd_pkg::A_EPST: next_s.rdat = {16'h0000, s.eps};
                usbd_pkg::A_BUS:  next_s.rdat = {28'h0, s.vb[1], s.dm[1], s.dp[1], s.susp};
                default:
                begin
                    next_s.rdat = 32'h00000000;
                    if (addr[9:5] == usbd_pkg::A_EPCFG[9:5])
                    begin
                        next_s.rdat = {8'h00, s.ep[addr[4:2]]};
                    end
                end
            endcase
        end
        if (s.se0 || !line_j || s.rwkc != '0)
        begin
            next_s.idle = '0;
        end
        else if (s.idle != CW'(SUSP_CYC - 1))
        begin
            next_s.idle = s.idle + 1'b1;
        end
        if (!s.susp && s.idle == CW'(SUSP_CYC - 2) && next_s.idle == CW'(SUSP_CYC - 1))
        begin
            next_s.susp = 1'b1;
            set_i[usbd_pkg::I_BUS] = 1'b1;
        end
        // Own K drive is not a resume; the host's answer after it is
        if (s.susp && !line_j && !s.se0 && s.rwkc == '0)
        begin
            next_s.susp = 1'b0;
            set_i[usbd_pkg::I_BUS]  = 1'b1;
            set_i[usbd_pkg::I_WAKE] = 1'b1;
        end
        // remote wake K
        // Two extra quiet counts mask our own K still in the synchroniser
        if (s.rwk && s.susp && s.rwkc == '0 && !s.se0)
        begin
            next_s.rwkc = CW'(RWK_CYC + 2);
            next_s.rwk  = 1'b0;
        end
        else if (s.rwkc != '0)
        begin
            next_s.rwkc = s.rwkc - 1'b1;
        end
        next_s.kdrv = (next_s.rwkc > CW'(2));
        if (f_fire)
        begin
            next_s.ptr = s.ptr + 1'b1;
            next_s.cnt = s.cnt + 1'b1;
        end
        if (s.rdp)
        begin
            next_s.txv = 1'b1;
            next_s.txd = mem_q;
            next_s.txl = (s.cnt == '0);
            next_s.rdp = 1'b0;
        end
        if (s.txv && tx_ready)
        begin
            next_s.txv = 1'b0;
        end
        case (s.fsm)
            usbd_pkg::FS_IDLE:
            begin
                if (tok.valid && !s.se0)
                begin
                    if (tok_ok)
                    begin
                        next_s.cur   = tok.ep;
                        next_s.setup = tok.setup;
                        next_s.ptr   = te.seg;
                        next_s.cnt   = tok.dir_in ? te.cnt : 10'h000;
                        next_s.endp  = 1'b0;
                        next_s.fsm   = tok.dir_in ? usbd_pkg::FS_IN : usbd_pkg::FS_OUT;
                    end
                    else
                    begin
                        next_s.nak = 1'b1;
                    end
                end
            end
            usbd_pkg::FS_OUT:
            begin
                if (rx_end)
                begin
                    next_s.endp = 1'b1;
                end
                if (s.endp && !f_ov)
                begin
                    next_s.ep[s.cur].cnt   = s.cnt;
                    next_s.ep[s.cur].armed = 1'b0;
                    next_s.ep[s.cur].tog   = ~s.ep[s.cur].tog;
                    next_s.eps[2*s.cur +: 2] = s.setup ? usbd_pkg::ST_SETUP
                                                        : usbd_pkg::ST_OUTAK;
                    set_e[s.cur] = 1'b1;
                    set_i[usbd_pkg::I_USB] = 1'b1;
                    next_s.ack  = 1'b1;
                    next_s.endp = 1'b0;
                    next_s.fsm  = usbd_pkg::FS_IDLE;
                end
            end
            usbd_pkg::FS_IN:
            begin
                if (!s.rdp && !s.txv && s.cnt != '0 && !bus_buf)
                begin
                    next_s.rdp = 1'b1;
                    next_s.ptr = s.ptr + 1'b1;
                    next_s.cnt = s.cnt - 1'b1;
                end
                if (!s.rdp && !s.txv && s.cnt == '0)
                begin
                    next_s.fsm = usbd_pkg::FS_INW;
                end
            end
            usbd_pkg::FS_INW:
            begin
                if (hs_ack)
                begin
                    next_s.ep[s.cur].armed = 1'b0;
                    next_s.ep[s.cur].tog   = ~s.ep[s.cur].tog;
                    next_s.eps[2*s.cur +: 2] = usbd_pkg::ST_INACK;
                    set_e[s.cur] = 1'b1;
                    set_i[usbd_pkg::I_USB] = 1'b1;
                    next_s.fsm = usbd_pkg::FS_IDLE;
                end
                else if (tok.valid)
                begin
                    next_s.fsm = usbd_pkg::FS_IDLE;
                end
            end
            default:
            begin
                next_s.fsm = usbd_pkg::FS_IDLE;
            end
        endcase
        if (s.se0)
        begin
            next_s.fsm  = usbd_pkg::FS_IDLE;
            next_s.rdp  = 1'b0;
            next_s.txv  = 1'b0;
            next_s.endp = 1'b0;
        end
        next_s.ints = (s.ints & ~clr_i) | set_i;
        next_s.epf  = (s.epf & ~clr_e) | set_e;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s     <= '0;
            s.fsm <= usbd_pkg::FS_IDLE;
            s.ep  <= {NE{usbd_pkg::EP_RST}};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rdata     = s.rdbuf ? {24'h000000, mem_q} : s.rdat;
    assign tx_valid  = s.txv;
    assign tx_data   = s.txd;
    assign tx_last   = s.txl;
    assign resp_ack  = s.ack;
    assign resp_nak  = s.nak;
    assign ep_toggle = s.ep[s.cur].tog;
    // SE0 has both lines low; K is D- high
    assign dp_o      = 1'b0;
    assign dm_o      = s.kdrv & ~s.se0;
    assign dp_oe     = s.se0 | s.kdrv;
    assign irq       = (|s.ints) | (|s.epf);
    assign suspended = s.susp;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence q_bwr;
        wr_en && addr[usbd_pkg::BUF_SEL];
    endsequence
    sequence q_brd;
        rd_en && $stable(addr);
    endsequence

    a_buf_roundtrip: assert property (q_bwr ##1 q_brd |=> rdata[7:0] == $past(wdata[7:0], 2))
        else $error("buffer read does not return written byte");
    a_seg_start: assert property ((s.fsm == usbd_pkg::FS_IDLE && tok.valid && !s.se0 && tok_ok)
        |=> s.ptr == $past(te.seg))
        else $error("transfer does not start at segment address");
    a_bad_tok_nak: assert property ((s.fsm == usbd_pkg::FS_IDLE && tok.valid && !s.se0 && !tok_ok)
        |=> resp_nak && s.fsm == usbd_pkg::FS_IDLE)
        else $error("refused token not answered by nak");
    a_in_toggle: assert property ((s.fsm == usbd_pkg::FS_INW && hs_ack && !s.se0)
        |=> s.ep[$past(s.cur)].tog != $past(ep_toggle) && s.fsm == usbd_pkg::FS_IDLE)
        else $error("IN ack did not flip toggle");
    a_out_event: assert property ((s.fsm == usbd_pkg::FS_OUT && s.endp && !f_ov && !s.se0)
        |=> resp_ack && irq && s.ints[usbd_pkg::I_USB])
        else $error("OUT completion did not raise event");
    a_se0_lines: assert property (s.se0 |-> dp_oe && !dp_o && !dm_o ##1 s.fsm == usbd_pkg::FS_IDLE)
        else $error("forced SE0 not driven or engine active");
    a_susp_entry: assert property ((!s.susp && s.idle == CW'(SUSP_CYC - 2) && line_j
        && !s.se0 && s.rwkc == '0) |=> suspended && s.ints[usbd_pkg::I_BUS])
        else $error("suspend not entered after idle time");
    a_rwk_drive: assert property ((s.rwk && s.susp && s.rwkc == '0 && !s.se0)
        |=> (dp_oe && dm_o && !dp_o) [*2])
        else $error("remote wake K not driven");
    a_flag_sticky: assert property (!(wr_en && addr == usbd_pkg::A_INT)
        |=> (s.ints & $past(s.ints)) == $past(s.ints))
        else $error("event flag dropped without write");
endmodule

`default_nettype wire

// file: tb/usbd_host_model.sv
// Host and serial engine stand-in facing the USB device endpoint block.
// Assumes one clock; each task first waits for a rising edge, so it may be called at any time.
`timescale 1ns/100ps
`default_nettype none
module usbd_host_model (
    input  wire logic          clk,      // System clock
    output var usbd_pkg::usbd_tok_s tok, // Token to device
    output logic               rx_valid, // OUT byte valid
    output logic [7:0]         rx_data,  // OUT byte
    output logic               rx_end,   // OUT packet end
    input  wire logic          rx_ready, // OUT byte taken
    input  wire logic          tx_valid, // IN byte valid
    input  wire logic [7:0]    tx_data,  // IN byte
    input  wire logic          tx_last,  // Last IN byte
    output logic               tx_ready, // IN byte accept
    output logic               hs_ack,   // Host handshake
    input  wire logic          resp_ack, // OUT stored
    input  wire logic          resp_nak, // Token refused
    input  wire logic          dp_o,     // Device D+ drive
    input  wire logic          dm_o,     // Device D- drive
    input  wire logic          dp_oe,    // Device drives lines
    output logic               dp_i,     // D+ wire level
    output logic               dm_i,     // D- wire level
    output logic               vbus_i    // Cable power
);
    logic [1:0] mode    = 2'h0;
    logic       host_dp = 1'h1;
    initial
    begin
        tok = '0;
        {rx_valid, rx_data, rx_end, tx_ready, hs_ack} = '0;
        vbus_i = 1'h1;
    end
    // Mode 0 toggles J/K as bus traffic, 1 idles in J, 2 holds a host K
    always @(posedge clk)
        host_dp <= (mode == 2'h0) ? ~host_dp : (mode == 2'h1);
    // Device drive wins while its enable is up
    assign dp_i = dp_oe ? dp_o : host_dp;
    assign dm_i = dp_oe ? dm_o : ~host_dp;

    task automatic lines(input logic [1:0] m, input logic v);
        @(posedge clk);
        mode   <= m;
        vbus_i <= v;
    endtask

    task automatic out_xfer(input logic su, input logic [2:0] ep, input logic [15:0] b,
                            input int gap, output logic [1:0] resp);
        int k;
        resp = 2'h0;
        @(posedge clk);
        tok <= '{valid: 1'h1, setup: su, dir_in: 1'h0, ep: ep};
        @(posedge clk);
        tok <= '0;
        repeat (2)
        begin
            @(negedge clk);
            if (resp_nak === 1'h1)
                resp = 2'h2;
        end
        if (resp != 2'h0)
            return;
        for (int i = 0; i < 2; i++)
        begin
            repeat (gap + 1) @(posedge clk);
            rx_valid <= 1'h1;
            rx_data  <= b[8*i+:8];
            k = 0;
            do
            begin
                @(negedge clk);
                k++;
            end while (rx_ready !== 1'h1 && k < 20);
            @(posedge clk);
            rx_valid <= 1'h0;
            rx_data  <= ~b[8*i+:8];
        end
        rx_end <= 1'h1;
        @(posedge clk);
        rx_end <= 1'h0;
        for (k = 0; k < 20 && resp == 2'h0; k++)
        begin
            @(negedge clk);
            if (resp_ack === 1'h1)
                resp = 2'h1;
        end
    endtask

    task automatic in_xfer(input logic [2:0] ep, input int gap, output logic [15:0] got,
                           output logic [1:0] lst);
        int k;
        @(posedge clk);
        tok <= '{valid: 1'h1, setup: 1'h0, dir_in: 1'h1, ep: ep};
        @(posedge clk);
        tok <= '0;
        for (int i = 0; i < 2; i++)
        begin
            k = 0;
            do
            begin
                @(negedge clk);
                k++;
            end while (tx_valid !== 1'h1 && k < 30);
            got[8*i+:8] = tx_data;
            lst[i]      = tx_last;
            // A slow engine leaves the byte waiting
            repeat (gap + 1) @(posedge clk);
            tx_ready <= 1'h1;
            @(posedge clk);
            tx_ready <= 1'h0;
        end
        // Handshake comes after the device has left its send state
        @(posedge clk);
        hs_ack <= 1'h1;
        @(posedge clk);
        hs_ack <= 1'h0;
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the USB device endpoint block.
// Assumes the host model drives every engine and line input.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int SUSP = 50;
    localparam int RWK  = 10;
    logic        clk = 1'h0, nrst = 1'h0, wr_en = 1'h0, rd_en = 1'h0;
    logic [9:0]  addr  = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [15:0] got;
    logic [1:0]  r, lst;
    usbd_pkg::usbd_tok_s tok;
    logic        rx_valid, rx_end, rx_ready, tx_valid, tx_last, tx_ready, hs_ack, resp_ack;
    logic        resp_nak, ep_toggle, dp_i, dm_i, vbus_i, dp_o, dm_o, dp_oe, irq, suspended;
    logic [7:0]  rx_data, tx_data;
    int          n_errors = 0, tests_run = 0, k;

    always #20 clk = ~clk;

    // Every port meets the bench signal of the same name
    usbd_core #(.SUSP_CYC(SUSP), .RWK_CYC(RWK)) dut_u (.*);
    usbd_host_model host_u (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
        #1;
    endtask
    // Buffer read data stand only in the cycle after the strobe; register read data hold until the next read
    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        #1 d = rdata;
    endtask
    task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
        rd(a);
        check(d, exp);
    endtask
    function automatic logic [31:0] cfg(input logic [8:0] seg, input logic [9:0] cnt,
        input logic din, input logic arm, input logic [1:0] ty, input logic tg);
        return {8'h00, tg, ty, arm, din, cnt, seg};
    endfunction
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #(40 * 6000);
        n_errors++;
        summarize();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        repeat (4) @(posedge clk);
        rdc(usbd_pkg::A_CTRL, 32'h0);
        rdc(10'h100, 32'h0);
        rdc(usbd_pkg::A_INT, 32'h2);
        wr(usbd_pkg::A_INT, 32'h2);
        rdc(usbd_pkg::A_INT, 32'h0);
        wr(10'h3FF, 32'hA5);
        wr(10'h200, 32'h15A);
        rdc(10'h3FF, 32'hA5);
        rdc(10'h200, 32'h5A);
        // Buffer write and read back to back
        @(posedge clk);
        {wr_en, addr, wdata} <= {1'h1, 10'h204, 32'h77};
        @(posedge clk);
        {wr_en, rd_en} <= 2'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        #1 check(rdata, 32'h77);
        for (int n = 0; n < 8; n++)
            wr(usbd_pkg::A_EPCFG + 10'(4 * n), cfg(9'(n * 64), 10'(n), n[0], 1'h0, n[1:0], 1'h0));
        for (int n = 0; n < 8; n++)
            rdc(usbd_pkg::A_EPCFG + 10'(4 * n), cfg(9'(n * 64), 10'(n), n[0], 1'h0, n[1:0], 1'h0));
        // OUT data wraps from the top of the buffer
        wr(usbd_pkg::A_EPCFG + 10'h4, cfg(9'h1FF, 10'h0, 1'h0, 1'h1, 2'h2, 1'h0));
        host_u.out_xfer(1'h0, 3'h1, 16'hC33C, 2, r);
        check(r, 2'h1);
        rdc(10'h3FF, 32'h3C);
        rdc(10'h200, 32'hC3);
        rdc(usbd_pkg::A_EPCFG + 10'h4, cfg(9'h1FF, 10'h2, 1'h0, 1'h0, 2'h2, 1'h1));
        rd(usbd_pkg::A_EPST);
        check(d[3:2], 2'h2);
        check(irq, 1'h1);
        rdc(usbd_pkg::A_INT, 32'h0002_0004);
        wr(usbd_pkg::A_INT, 32'h0);
        rdc(usbd_pkg::A_INT, 32'h0002_0004);
        wr(usbd_pkg::A_INT, 32'h0002_0000);
        rdc(usbd_pkg::A_INT, 32'h4);
        wr(usbd_pkg::A_INT, '1);
        check(irq, 1'h0);
        wr(usbd_pkg::A_EPCFG, cfg(9'h040, 10'h0, 1'h0, 1'h1, 2'h0, 1'h0));
        host_u.out_xfer(1'h1, 3'h0, 16'h8001, 0, r);
        check(r, 2'h1);
        rd(usbd_pkg::A_EPST);
        check(d[1:0], 2'h3);
        rdc(10'h241, 32'h80);
        wr(usbd_pkg::A_INT, '1);
        wr(10'h280, 32'h11);
        wr(10'h281, 32'h22);
        wr(usbd_pkg::A_EPCFG + 10'h8, cfg(9'h080, 10'h2, 1'h1, 1'h1, 2'h1, 1'h1));
        host_u.in_xfer(3'h2, 3, got, lst);
        check(got, 16'h2211);
        check(lst, 2'h2);
        rd(usbd_pkg::A_EPST);
        check(d[5:4], 2'h1);
        rdc(usbd_pkg::A_EPCFG + 10'h8, cfg(9'h080, 10'h2, 1'h1, 1'h0, 2'h1, 1'h0));
        rdc(usbd_pkg::A_INT, 32'h0004_0004);
        wr(usbd_pkg::A_INT, '1);
        // Wrong direction is refused for both token kinds
        wr(usbd_pkg::A_EPCFG + 10'hC, cfg(9'h0C0, 10'h0, 1'h1, 1'h1, 2'h3, 1'h0));
        for (int s = 0; s < 2; s++)
        begin
            host_u.out_xfer(s[0], 3'h3, 16'h0102, 0, r);
            check(r, 2'h2);
        end
        wr(usbd_pkg::A_EPCFG + 10'h14, cfg(9'h140, 10'h0, 1'h0, 1'h1, 2'h2, 1'h0));
        wr(usbd_pkg::A_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        #1 check({dp_oe, dp_o, dm_o}, 3'h4);
        host_u.out_xfer(1'h0, 3'h5, 16'h0304, 0, r);
        check(r, 2'h0);
        rdc(usbd_pkg::A_EPCFG + 10'h14, cfg(9'h140, 10'h0, 1'h0, 1'h1, 2'h2, 1'h0));
        wr(usbd_pkg::A_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        #1 check(dp_oe, 1'h0);
        wr(usbd_pkg::A_INT, '1);
        host_u.lines(2'h1, 1'h1);
        for (k = 0; suspended !== 1'h1 && k < SUSP + 20; k++)
            @(negedge clk);
        check(k >= SUSP && k <= SUSP + 8, 1'h1);
        rdc(usbd_pkg::A_INT, 32'h8);
        rdc(usbd_pkg::A_BUS, 32'hB);
        wr(usbd_pkg::A_INT, '1);
        wr(usbd_pkg::A_CTRL, 32'h2);
        for (k = 0; dp_oe !== 1'h1 && k < 10; k++)
            @(negedge clk);
        for (k = 0; dp_oe === 1'h1 && {dp_o, dm_o} === 2'h1 && k < RWK + 20; k++)
            @(negedge clk);
        check(k >= RWK && k <= RWK + 1, 1'h1);
        wr(usbd_pkg::A_INT, '1);
        host_u.lines(2'h2, 1'h1);
        repeat (20) @(posedge clk);
        host_u.lines(2'h0, 1'h1);
        repeat (4) @(posedge clk);
        #1 check(suspended, 1'h0);
        rdc(usbd_pkg::A_INT, 32'h9);
        wr(usbd_pkg::A_INT, '1);
        host_u.lines(2'h0, 1'h0);
        repeat (6) @(posedge clk);
        rdc(usbd_pkg::A_INT, 32'h2);
        summarize();
    end
endmodule
`default_nettype wire
